// >>> pkg/cdbu_pkg.sv
`default_nettype none
package cdbu_pkg;
  // Processor-status register numbers
  localparam logic [7:0] OFS_SAVED_STATUS  = 8'h10;
  localparam logic [7:0] OFS_SAVED_PC      = 8'h11;
  localparam logic [7:0] OFS_SAVED_SP      = 8'h12;
  localparam logic [7:0] OFS_READ_THREAD   = 8'h13;
  localparam logic [7:0] OFS_READ_INDEX    = 8'h14;
  localparam logic [7:0] OFS_ENTRY_CAUSE   = 8'h15;
  localparam logic [7:0] OFS_EVENT_DATA    = 8'h16;
  localparam logic [7:0] OFS_STOP_VECTOR   = 8'h18;
  localparam logic [7:0] OFS_SCRATCH       = 8'h20;
  localparam logic [7:0] OFS_IBRK_TARGET   = 8'h30;
  localparam logic [7:0] OFS_IBRK_CONFIG   = 8'h40;
  localparam logic [7:0] OFS_DWATCH_FIRST  = 8'h50;
  localparam logic [7:0] OFS_DWATCH_SECOND = 8'h60;
  localparam logic [7:0] OFS_DWATCH_CONFIG = 8'h70;
  localparam logic [7:0] OFS_RWATCH_MASK   = 8'h80;
  localparam logic [7:0] OFS_RWATCH_VALUE  = 8'h90;
  localparam logic [7:0] OFS_RWATCH_CONFIG = 8'h9c;
  // Tile configuration numbers
  localparam logic [7:0] OFS_TILE_DEBUG    = 8'h05;
  localparam logic [7:0] OFS_TILE_SCRATCH  = 8'h20;
  // Saved status writable bits 10,9,7,6,4..0
  localparam logic [31:0] SAVED_STATUS_WMASK = 32'h0000_06df;
  localparam int          SSR_ISSUE_MODE_BIT = 8;
  // Config fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_MODE_BIT   = 1;
  localparam int CFG_LOAD_BIT   = 2;
  localparam int CFG_MASK_LSB   = 16;
  localparam int CAUSE_IDX_LSB  = 16;
  localparam int CAUSE_THR_LSB  = 8;
  localparam logic [31:0] IBRK_CONFIG_WMASK   = 32'h00ff_0003;
  localparam logic [31:0] DWATCH_CONFIG_WMASK = 32'h00ff_0007;
  localparam logic [31:0] RWATCH_CONFIG_WMASK = 32'h00ff_0003;
  localparam logic [31:0] CAUSE_WMASK         = 32'h0003_ff07;
  localparam logic [31:0] CONFIG_RESET        = 32'h0000_0000;
  localparam logic [31:0] CAUSE_RESET         = 32'h0000_0000;
  // Entry cause codes
  localparam logic [2:0] CAUSE_HOST  = 3'h1;
  localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;
  localparam logic [2:0] CAUSE_IBRK  = 3'h3;
  localparam logic [2:0] CAUSE_DATA  = 3'h4;
  localparam logic [2:0] CAUSE_RES   = 3'h5;
  localparam int NUM_THREADS = 8;
  localparam int NUM_POINTS  = 4;
  localparam int NUM_SCRATCH = 8;
endpackage
`default_nettype wire

// >>> rtl/cdbu_core.sv
// How it works
// - On debug entry capture saved status word into readable, writable copy.
// - Status copy bits 10,9,7,6,4..0 writable; bit 8 read-only issue mode.
// - On debug entry copy saved program counter into writable register.
// - On debug entry copy saved stack pointer into writable register.
// - Register-read op takes thread from 8-bit field, index from 5-bit field.
// - Cause field 3 bits, reset 0: host, call, ibreak, data, resource.
// - Trigger index 2 bits, lowest wins, zero for host and call.
// - Causing thread number 8 bits, zero for host request.
// - Event data holds address on data hit, resource id on resource hit.
// - Outside debug mode stop vector threads are held from executing.
// - Eight scratch words, shared with tile configuration space.
// - Four instruction breakpoints trigger on program counter address condition.
// - Instruction config: bit0 enable, bit1 equal or not-equal; reset 0.
// - Every breakpoint has 8-bit thread mask, reset 0, gating triggers.
// - Four data watchpoints with first and second address registers.
// - Data config: bit0 enable, bit1 AND/OR, bit2 loads allowed; reset 0.
// - Four resource watchpoints with mask and value registers.
// - Resource config: bit0 enable, bit1 selects mask/value match or mismatch.
// - Host requests debug via tile bit 0; bit 1 shows debug mode.
`timescale 1ns/100ps
`default_nettype none
module cdbu_core
  import cdbu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Processor-status access
  input  wire logic        ps_write,
  input  wire logic        ps_read,
  input  wire logic [7:0]  ps_addr,
  input  wire logic [31:0] ps_wdata,
  output logic      [31:0] ps_rdata,
  // Tile configuration access
  input  wire logic        tc_write,
  input  wire logic        tc_read,
  input  wire logic [7:0]  tc_addr,
  input  wire logic [31:0] tc_wdata,
  output logic      [31:0] tc_rdata,
  // Core observation
  input  wire logic [2:0]  exec_thread,
  input  wire logic        exec_valid,
  input  wire logic [31:0] exec_pc,
  input  wire logic        mem_valid,
  input  wire logic        mem_load,
  input  wire logic [31:0] mem_addr,
  input  wire logic        res_valid,
  input  wire logic [31:0] res_id,
  input  wire logic        debug_call_instruction_valid,
  input  wire logic [31:0] cur_status,
  input  wire logic [31:0] cur_pc,
  input  wire logic [31:0] cur_sp,
  input  wire logic        debug_return,
  // Debug control outputs
  output logic             debug_entry,
  output logic             debug_mode,
  output logic      [7:0]  thread_hold,
  output logic      [7:0]  read_thread,
  output logic      [4:0]  read_index
);
  logic [31:0] saved_status_copy;
  logic [31:0] saved_program_counter_copy;
  logic [31:0] saved_stack_pointer_copy;
  logic [31:0] debug_entry_cause;
  logic [31:0] debug_event_data;
  logic [7:0]  thread_stop_vector;
  logic        host_request;
  logic [31:0] monitor_scratch_words   [NUM_SCRATCH];
  logic [31:0] instr_break_target      [NUM_POINTS];
  logic [31:0] instr_break_config      [NUM_POINTS];
  logic [31:0] data_watch_first_address  [NUM_POINTS];
  logic [31:0] data_watch_second_address [NUM_POINTS];
  logic [31:0] data_watch_config       [NUM_POINTS];
  logic [31:0] resource_watch_mask     [NUM_POINTS];
  logic [31:0] resource_watch_value    [NUM_POINTS];
  logic [31:0] resource_watch_config   [NUM_POINTS];

  logic [3:0] ibrk_hit;
  logic [3:0] dwatch_hit;
  logic [3:0] rwatch_hit;
  logic       any_hit;
  logic       enter;
  logic [2:0] next_cause;
  logic [1:0] next_index;
  logic [7:0] next_thread;
  logic [7:0] thread_bit;

  assign thread_bit = 8'h01 << exec_thread;

  genvar g;
  generate
    for (g = 0; g < NUM_POINTS; g++) begin : g_match
      logic ib_eq;
      logic da;
      logic db;
      logic ra;
      assign ib_eq = (exec_pc == instr_break_target[g]);
      assign ibrk_hit[g] = exec_valid && instr_break_config[g][CFG_ENABLE_BIT]
        && |(instr_break_config[g][CFG_MASK_LSB +: 8] & thread_bit)
        && (instr_break_config[g][CFG_MODE_BIT] ? !ib_eq : ib_eq);
      assign da = (mem_addr >= data_watch_first_address[g]);
      assign db = (mem_addr <= data_watch_second_address[g]);
      assign dwatch_hit[g] = mem_valid && data_watch_config[g][CFG_ENABLE_BIT]
        && (!mem_load || data_watch_config[g][CFG_LOAD_BIT])
        && |(data_watch_config[g][CFG_MASK_LSB +: 8] & thread_bit)
        && (data_watch_config[g][CFG_MODE_BIT] ? (da || db) : (da && db));
      assign ra = ((res_id & resource_watch_mask[g])
                   == (resource_watch_value[g] & resource_watch_mask[g]));
      assign rwatch_hit[g] = res_valid && resource_watch_config[g][CFG_ENABLE_BIT]
        && |(resource_watch_config[g][CFG_MASK_LSB +: 8] & thread_bit)
        && (resource_watch_config[g][CFG_MODE_BIT] ? !ra : ra);
    end
  endgenerate

  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[0]) r = 2'h0;
    else if (v[1]) r = 2'h1;
    else if (v[2]) r = 2'h2;
    else if (v[3]) r = 2'h3;
    return r;
  endfunction

  assign any_hit = (|ibrk_hit) || (|dwatch_hit) || (|rwatch_hit);
  assign enter   = !debug_mode && (host_request || debug_call_instruction_valid || any_hit);

  always_comb begin
    next_cause  = CAUSE_HOST;
    next_index  = 2'h0;
    next_thread = 8'h00;
    if (host_request) begin
      next_cause = CAUSE_HOST;
    end else if (debug_call_instruction_valid) begin
      next_cause  = CAUSE_DEBUG_CALL_INSTRUCTION;
      next_thread = {5'h00, exec_thread};
    end else if (|ibrk_hit) begin
      next_cause  = CAUSE_IBRK;
      next_index  = lowest(ibrk_hit);
      next_thread = {5'h00, exec_thread};
    end else if (|dwatch_hit) begin
      next_cause  = CAUSE_DATA;
      next_index  = lowest(dwatch_hit);
      next_thread = {5'h00, exec_thread};
    end else begin
      next_cause  = CAUSE_RES;
      next_index  = lowest(rwatch_hit);
      next_thread = {5'h00, exec_thread};
    end
  end

  logic ps_wr_status;
  logic ps_wr_pc;
  logic ps_wr_sp;
  logic ps_wr_cause;
  logic ps_wr_data;
  logic tc_wr_debug;
  assign ps_wr_status = ps_write && (ps_addr == OFS_SAVED_STATUS);
  assign ps_wr_pc     = ps_write && (ps_addr == OFS_SAVED_PC);
  assign ps_wr_sp     = ps_write && (ps_addr == OFS_SAVED_SP);
  assign ps_wr_cause  = ps_write && (ps_addr == OFS_ENTRY_CAUSE);
  assign ps_wr_data   = ps_write && (ps_addr == OFS_EVENT_DATA);
  assign tc_wr_debug  = tc_write && (tc_addr == OFS_TILE_DEBUG);
  logic ps_wr_stop;
  logic ps_wr_thread;
  logic ps_wr_index;
  assign ps_wr_stop   = ps_write && (ps_addr == OFS_STOP_VECTOR);
  assign ps_wr_thread = ps_write && (ps_addr == OFS_READ_THREAD);
  assign ps_wr_index  = ps_write && (ps_addr == OFS_READ_INDEX);
  logic        watch_entry;
  logic [31:0] status_capture;
  logic [31:0] next_event_data;
  assign watch_entry     = !host_request && !debug_call_instruction_valid && !(|ibrk_hit);
  assign status_capture  = cur_status & (SAVED_STATUS_WMASK | (32'h1 << SSR_ISSUE_MODE_BIT));
  assign next_event_data = (|dwatch_hit) ? mem_addr : res_id;

  // Entry capture; hardware entry wins over software write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      saved_status_copy          <= 32'h0000_0000;
      saved_program_counter_copy <= 32'h0000_0000;
      saved_stack_pointer_copy   <= 32'h0000_0000;
      debug_entry_cause          <= CAUSE_RESET;
      debug_event_data           <= 32'h0000_0000;
    end else if (enter) begin
      saved_status_copy          <= status_capture;
      saved_program_counter_copy <= cur_pc;
      saved_stack_pointer_copy   <= cur_sp;
      debug_entry_cause          <= {14'h0000, next_index, next_thread, 5'h00, next_cause};
      if (watch_entry)
        debug_event_data <= next_event_data;
    end else begin
      if (ps_wr_status)
        saved_status_copy <= (ps_wdata & SAVED_STATUS_WMASK)
                             | (saved_status_copy & ~SAVED_STATUS_WMASK);
      if (ps_wr_pc)
        saved_program_counter_copy <= ps_wdata;
      if (ps_wr_sp)
        saved_stack_pointer_copy <= ps_wdata;
      if (ps_wr_cause)
        debug_entry_cause <= ps_wdata & CAUSE_WMASK;
      if (ps_wr_data)
        debug_event_data <= ps_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_request <= 1'b0;
      debug_mode   <= 1'b0;
      debug_entry  <= 1'b0;
    end else begin
      debug_entry <= enter;
      if (enter)
        debug_mode <= 1'b1;
      else if (debug_return)
        debug_mode <= 1'b0;
      if (enter)
        host_request <= 1'b0;
      else if (tc_wr_debug)
        host_request <= tc_wdata[0];
    end
  end

  // Plain control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      thread_stop_vector <= 8'h00;
      read_thread        <= 8'h00;
      read_index         <= 5'h00;
    end else begin
      if (ps_wr_stop)
        thread_stop_vector <= ps_wdata[7:0];
      if (ps_wr_thread)
        read_thread <= ps_wdata[7:0];
      if (ps_wr_index)
        read_index <= ps_wdata[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      thread_hold <= 8'h00;
    else if (enter || debug_mode)
      thread_hold <= 8'h00;
    else
      thread_hold <= thread_stop_vector;
  end

  generate
    for (g = 0; g < NUM_SCRATCH; g++) begin : g_scratch
      always_ff @(posedge clock) begin
        if (!rst_n)
          monitor_scratch_words[g] <= 32'h0000_0000;
        else if (ps_write && ps_addr == OFS_SCRATCH + 8'(g))
          monitor_scratch_words[g] <= ps_wdata;
        else if (tc_write && tc_addr == OFS_TILE_SCRATCH + 8'(g))
          monitor_scratch_words[g] <= tc_wdata;
      end
    end
    for (g = 0; g < NUM_POINTS; g++) begin : g_points
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          instr_break_target[g]        <= 32'h0000_0000;
          instr_break_config[g]        <= CONFIG_RESET;
          data_watch_first_address[g]  <= 32'h0000_0000;
          data_watch_second_address[g] <= 32'h0000_0000;
          data_watch_config[g]         <= CONFIG_RESET;
          resource_watch_mask[g]       <= 32'h0000_0000;
          resource_watch_value[g]      <= 32'h0000_0000;
          resource_watch_config[g]     <= CONFIG_RESET;
        end else if (ps_write) begin
          if (ps_addr == OFS_IBRK_TARGET + 8'(g))
            instr_break_target[g] <= ps_wdata;
          if (ps_addr == OFS_DWATCH_FIRST + 8'(g))
            data_watch_first_address[g] <= ps_wdata;
          if (ps_addr == OFS_DWATCH_SECOND + 8'(g))
            data_watch_second_address[g] <= ps_wdata;
          if (ps_addr == OFS_RWATCH_MASK + 8'(g))
            resource_watch_mask[g] <= ps_wdata;
          if (ps_addr == OFS_RWATCH_VALUE + 8'(g))
            resource_watch_value[g] <= ps_wdata;
          if (ps_addr == OFS_IBRK_CONFIG + 8'(g))
            instr_break_config[g] <= ps_wdata & IBRK_CONFIG_WMASK;
          if (ps_addr == OFS_DWATCH_CONFIG + 8'(g))
            data_watch_config[g] <= ps_wdata & DWATCH_CONFIG_WMASK;
          if (ps_addr == OFS_RWATCH_CONFIG + 8'(g))
            resource_watch_config[g] <= ps_wdata & RWATCH_CONFIG_WMASK;
        end
      end
    end
  endgenerate

  // Read multiplexers
  logic [31:0] ps_mux;
  logic [31:0] tc_mux;
  logic [1:0]  pi;
  logic [2:0]  si;
  logic [2:0]  ti;
  assign pi = ps_addr[1:0];
  assign si = ps_addr[2:0];
  assign ti = tc_addr[2:0];

  always_comb begin
    ps_mux = 32'h0000_0000;
    case (ps_addr[7:4])
      4'h1: begin
        case (ps_addr)
          OFS_SAVED_STATUS: ps_mux = saved_status_copy;
          OFS_SAVED_PC:     ps_mux = saved_program_counter_copy;
          OFS_SAVED_SP:     ps_mux = saved_stack_pointer_copy;
          OFS_READ_THREAD:  ps_mux = {24'h000000, read_thread};
          OFS_READ_INDEX:   ps_mux = {27'h0000000, read_index};
          OFS_ENTRY_CAUSE:  ps_mux = debug_entry_cause;
          OFS_EVENT_DATA:   ps_mux = debug_event_data;
          OFS_STOP_VECTOR:  ps_mux = {24'h000000, thread_stop_vector};
          default:          ps_mux = 32'h0000_0000;
        endcase
      end
      4'h2: ps_mux = ps_addr[3] ? 32'h0000_0000 : monitor_scratch_words[si];
      4'h3: ps_mux = (ps_addr[3:2] == 2'h0) ? instr_break_target[pi] : 32'h0000_0000;
      4'h4: ps_mux = (ps_addr[3:2] == 2'h0) ? instr_break_config[pi] : 32'h0000_0000;
      4'h5: ps_mux = (ps_addr[3:2] == 2'h0) ? data_watch_first_address[pi] : 32'h0000_0000;
      4'h6: ps_mux = (ps_addr[3:2] == 2'h0) ? data_watch_second_address[pi] : 32'h0000_0000;
      4'h7: ps_mux = (ps_addr[3:2] == 2'h0) ? data_watch_config[pi] : 32'h0000_0000;
      4'h8: ps_mux = (ps_addr[3:2] == 2'h0) ? resource_watch_mask[pi] : 32'h0000_0000;
      4'h9: begin
        if (ps_addr[3:2] == 2'h0)
          ps_mux = resource_watch_value[pi];
        else if (ps_addr[3:2] == 2'h3)
          ps_mux = resource_watch_config[pi];
        else
          ps_mux = 32'h0000_0000;
      end
      default: ps_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    tc_mux = 32'h0000_0000;
    if (tc_addr == OFS_TILE_DEBUG)
      tc_mux = {30'h00000000, debug_mode, host_request};
    else if (tc_addr[7:3] == OFS_TILE_SCRATCH[7:3])
      tc_mux = monitor_scratch_words[ti];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ps_rdata <= 32'h0000_0000;
      tc_rdata <= 32'h0000_0000;
    end else begin
      ps_rdata <= ps_read ? ps_mux : 32'h0000_0000;
      tc_rdata <= tc_read ? tc_mux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/cdbu_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cdbu_assert_chk
  import cdbu_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ps_write,
  input wire logic [7:0]  ps_addr,
  input wire logic [31:0] ps_wdata,
  input wire logic        tc_write,
  input wire logic        tc_read,
  input wire logic [7:0]  tc_addr,
  input wire logic [31:0] tc_wdata,
  input wire logic [31:0] tc_rdata,
  input wire logic        debug_return,
  input wire logic        debug_entry,
  input wire logic        debug_mode,
  input wire logic [7:0]  thread_hold,
  input wire logic [7:0]  read_thread,
  input wire logic [4:0]  read_index
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_host_req;
    tc_write && tc_addr == OFS_TILE_DEBUG && tc_wdata[0] && !debug_mode && !debug_return;
  endsequence
  sequence s_in_debug;
    debug_mode && !debug_return;
  endsequence
  a_host_entry: assert property (s_host_req |-> ##[1:3] debug_mode)
    else $error("host request not taken");
  a_entry_pulse: assert property (debug_entry |-> debug_mode ##1 !debug_entry)
    else $error("entry pulse malformed");
  a_no_reentry: assert property (s_in_debug |=> !debug_entry)
    else $error("entry while in debug mode");
  a_return_exit: assert property (debug_return && debug_mode |=> !debug_mode)
    else $error("debug mode kept after return");
  a_hold_in_debug: assert property (debug_mode [*2] |-> thread_hold == 8'h00)
    else $error("threads held inside debug mode");
  a_thread_sel: assert property (ps_write && ps_addr == OFS_READ_THREAD |=> read_thread == $past(ps_wdata[7:0]))
    else $error("thread operand field wrong");
  a_index_sel: assert property (ps_write && ps_addr == OFS_READ_INDEX |=> read_index == $past(ps_wdata[4:0]))
    else $error("index operand field wrong");
  a_tile_status: assert property (tc_read && tc_addr == OFS_TILE_DEBUG |=>
    tc_rdata[31:1] == {30'h0, $past(debug_mode)})
    else $error("tile debug status bit wrong");
endmodule
`default_nettype wire

// >>> testbench/cdbu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cdbu_core_model (
  input  wire logic        clock,
  input  wire logic [7:0]  thread_hold,
  output logic      [2:0]  exec_thread,
  output logic             exec_valid,
  output logic      [31:0] exec_pc,
  output logic             mem_valid,
  output logic             mem_load,
  output logic      [31:0] mem_addr,
  output logic             res_valid,
  output logic      [31:0] res_id,
  output logic             debug_call_instruction_valid,
  output logic      [31:0] cur_status,
  output logic      [31:0] cur_pc,
  output logic      [31:0] cur_sp,
  output logic             debug_return
);
  initial begin
    {exec_valid, mem_valid, mem_load, res_valid, debug_call_instruction_valid, debug_return} = 6'h0;
    {exec_thread, exec_pc, mem_addr, res_id} = 99'h0;
    {cur_status, cur_pc, cur_sp} = 96'h0;
  end
  // Kinds: 0 issue, 1 load, 2 store, 3 resource, 4 debug call, 5 return
  task automatic op(input logic [2:0] kind, input logic [2:0] thr, input logic [31:0] val);
    logic run;
    @(negedge clock);
    run = !thread_hold[thr];
    exec_thread = thr;
    exec_pc = val;
    cur_pc = val;
    cur_status = 32'h0000_0550 | {29'h0, thr};
    cur_sp = 32'h0001_0000 + {29'h0, thr};
    exec_valid = run && kind == 3'h0;
    mem_valid = run && (kind == 3'h1 || kind == 3'h2);
    mem_load = kind == 3'h1;
    mem_addr = val;
    res_valid = run && kind == 3'h3;
    res_id = val;
    debug_call_instruction_valid = run && kind == 3'h4;
    debug_return = kind == 3'h5;
    @(negedge clock);
    {exec_valid, mem_valid, res_valid, debug_call_instruction_valid, debug_return} = 5'h0;
    exec_pc = ~exec_pc;
    mem_addr = ~mem_addr;
    res_id = ~res_id;
  endtask
endmodule
`default_nettype wire

// >>> testbench/cdbu_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
module cdbu_core_bench;
  import cdbu_pkg::*;
  logic        clock, rst_n, ps_write, ps_read, tc_write, tc_read;
  logic [7:0]  ps_addr, tc_addr, thread_hold, read_thread;
  logic [31:0] ps_wdata, tc_wdata, ps_rdata, tc_rdata, exec_pc, mem_addr, res_id, cur_status, cur_pc, cur_sp;
  logic [2:0]  exec_thread;
  logic        exec_valid, mem_valid, mem_load, res_valid, debug_call_instruction_valid, debug_return, debug_entry, debug_mode;
  logic [4:0]  read_index;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [7:0]  z_ofs [6] = '{8'h15, 8'h40, 8'h43, 8'h70, 8'h9c, 8'h9f};
  logic [7:0]  rw_ofs [15] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h33, 8'h43, 8'h53, 8'h63,
                               8'h73, 8'h83, 8'h93, 8'h9f};
  logic [31:0] rw_exp [15] = '{32'h0000_06df, '1, '1, 32'h0000_00ff, 32'h0000_001f, 32'h0003_ff07, '1, '1,
                               32'h00ff_0003, '1, '1, 32'h00ff_0007, '1, '1, 32'h00ff_0003};
  cdbu_core u_dut (
    .clock(clock), .rst_n(rst_n), .ps_write(ps_write), .ps_read(ps_read), .ps_addr(ps_addr),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .tc_write(tc_write), .tc_read(tc_read), .tc_addr(tc_addr),
    .tc_wdata(tc_wdata), .tc_rdata(tc_rdata), .exec_thread(exec_thread), .exec_valid(exec_valid),
    .exec_pc(exec_pc), .mem_valid(mem_valid), .mem_load(mem_load), .mem_addr(mem_addr), .res_valid(res_valid),
    .res_id(res_id), .debug_call_instruction_valid(debug_call_instruction_valid), .cur_status(cur_status), .cur_pc(cur_pc), .cur_sp(cur_sp),
    .debug_return(debug_return), .debug_entry(debug_entry), .debug_mode(debug_mode),
    .thread_hold(thread_hold), .read_thread(read_thread), .read_index(read_index));
  cdbu_core_model u_part (
    .clock(clock), .thread_hold(thread_hold), .exec_thread(exec_thread), .exec_valid(exec_valid),
    .exec_pc(exec_pc), .mem_valid(mem_valid), .mem_load(mem_load), .mem_addr(mem_addr), .res_valid(res_valid),
    .res_id(res_id), .debug_call_instruction_valid(debug_call_instruction_valid), .cur_status(cur_status), .cur_pc(cur_pc), .cur_sp(cur_sp),
    .debug_return(debug_return));
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Register access, t selects tile space, w write; a read compares against d
  task automatic acc(input logic t, input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clock);
    ps_write = w && !t;
    ps_read = !w && !t;
    tc_write = w && t;
    tc_read = !w && t;
    ps_addr = a;
    tc_addr = a;
    ps_wdata = d;
    tc_wdata = d;
    @(negedge clock);
    {ps_write, ps_read, tc_write, tc_read} = 4'h0;
    if (!w) chk(t ? "tc_rdata" : "ps_rdata", d, t ? tc_rdata : ps_rdata);
  endtask
  task automatic enter(input logic [31:0] cause);
    int i;
    for (i = 0; i < 10 && debug_mode !== 1'h1; i++) @(negedge clock);
    chk("debug_mode", 32'h1, {31'h0, debug_mode});
    acc(1'h0, 1'h0, OFS_ENTRY_CAUSE, cause);
  endtask
  task automatic quiet();
    repeat (4) @(negedge clock);
    chk("debug_mode", 32'h0, {31'h0, debug_mode});
  endtask
  initial begin
    rst_n = 1'h0;
    {ps_write, ps_read, tc_write, tc_read, ps_addr, tc_addr, ps_wdata, tc_wdata} = 84'h0;
    repeat (5) @(negedge clock);
    rst_n = 1'h1;
    foreach (z_ofs[i]) acc(1'h0, 1'h0, z_ofs[i], 32'h0);
    foreach (rw_ofs[i]) begin
      acc(1'h0, 1'h1, rw_ofs[i], '1);
      acc(1'h0, 1'h0, rw_ofs[i], rw_exp[i]);
      acc(1'h0, 1'h1, rw_ofs[i], 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      acc(1'h0, 1'h1, OFS_SCRATCH + 8'(i), 32'h5c00_0000 + i);
      acc(1'h1, 1'h0, OFS_TILE_SCRATCH + 8'(i), 32'h5c00_0000 + i);
      acc(1'h1, 1'h1, OFS_TILE_SCRATCH + 8'(i), 32'ha300_0000 + i);
      acc(1'h0, 1'h0, OFS_SCRATCH + 8'(i), 32'ha300_0000 + i);
    end
    acc(1'h1, 1'h1, OFS_TILE_DEBUG, 32'h1);
    enter(32'h0000_0001);
    acc(1'h1, 1'h0, OFS_TILE_DEBUG, 32'h2);
    acc(1'h0, 1'h1, OFS_STOP_VECTOR, 32'h24);
    chk("thread_hold", 32'h0, {24'h0, thread_hold});
    u_part.op(3'h5, 3'h0, 32'h0);
    repeat (3) @(negedge clock);
    chk("thread_hold", 32'h24, {24'h0, thread_hold});
    acc(1'h0, 1'h1, OFS_STOP_VECTOR, 32'h0);
    u_part.op(3'h4, 3'h5, 32'h0000_4a10);
    enter(32'h0000_0502);
    acc(1'h0, 1'h0, OFS_SAVED_PC, 32'h0000_4a10);
    acc(1'h0, 1'h0, OFS_SAVED_SP, 32'h0001_0005);
    acc(1'h0, 1'h0, OFS_SAVED_STATUS, 32'h0000_0555);
    u_part.op(3'h5, 3'h0, 32'h0);
    acc(1'h0, 1'h1, 8'h32, 32'h0000_8000);
    acc(1'h0, 1'h1, 8'h33, 32'h0000_8000);
    acc(1'h0, 1'h1, 8'h42, 32'h0008_0001);
    acc(1'h0, 1'h1, 8'h43, 32'h0008_0001);
    u_part.op(3'h0, 3'h4, 32'h0000_8000);
    quiet();
    u_part.op(3'h0, 3'h3, 32'h0000_8000);
    enter(32'h0002_0303);
    u_part.op(3'h5, 3'h0, 32'h0);
    acc(1'h0, 1'h1, 8'h30, 32'h0000_9000);
    acc(1'h0, 1'h1, 8'h40, 32'h0002_0003);
    u_part.op(3'h0, 3'h1, 32'h0000_9000);
    quiet();
    u_part.op(3'h0, 3'h1, 32'h0000_9004);
    enter(32'h0000_0103);
    u_part.op(3'h5, 3'h0, 32'h0);
    acc(1'h0, 1'h1, 8'h51, 32'h0000_1000);
    acc(1'h0, 1'h1, 8'h61, 32'h0000_1fff);
    acc(1'h0, 1'h1, 8'h71, 32'h0004_0001);
    u_part.op(3'h1, 3'h2, 32'h0000_1800);
    quiet();
    u_part.op(3'h2, 3'h2, 32'h0000_2000);
    quiet();
    u_part.op(3'h2, 3'h2, 32'h0000_1fff);
    enter(32'h0001_0204);
    acc(1'h0, 1'h0, OFS_EVENT_DATA, 32'h0000_1fff);
    u_part.op(3'h5, 3'h0, 32'h0);
    acc(1'h0, 1'h1, 8'h71, 32'h0004_0007);
    u_part.op(3'h1, 3'h2, 32'h0000_0010);
    enter(32'h0001_0204);
    acc(1'h0, 1'h0, OFS_EVENT_DATA, 32'h0000_0010);
    u_part.op(3'h5, 3'h0, 32'h0);
    acc(1'h0, 1'h1, 8'h80, 32'h0000_00ff);
    acc(1'h0, 1'h1, 8'h90, 32'h0000_0005);
    acc(1'h0, 1'h1, 8'h9c, 32'h0040_0003);
    u_part.op(3'h3, 3'h6, 32'h0000_0105);
    quiet();
    u_part.op(3'h3, 3'h6, 32'h0000_0006);
    enter(32'h0000_0605);
    acc(1'h0, 1'h0, OFS_EVENT_DATA, 32'h0000_0006);
    u_part.op(3'h5, 3'h0, 32'h0);
    acc(1'h0, 1'h1, 8'h9c, 32'h0040_0001);
    u_part.op(3'h3, 3'h6, 32'h0000_7705);
    enter(32'h0000_0605);
    acc(1'h0, 1'h0, OFS_EVENT_DATA, 32'h0000_7705);
    results();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    results();
  end
endmodule
bind cdbu_core cdbu_assert_chk u_chk (
  .clock(clock), .rst_n(rst_n), .ps_write(ps_write), .ps_addr(ps_addr), .ps_wdata(ps_wdata),
  .tc_write(tc_write), .tc_read(tc_read), .tc_addr(tc_addr), .tc_wdata(tc_wdata), .tc_rdata(tc_rdata),
  .debug_return(debug_return), .debug_entry(debug_entry), .debug_mode(debug_mode),
  .thread_hold(thread_hold), .read_thread(read_thread), .read_index(read_index));
`default_nettype wire
